// file: rtl/ssip_port.sv
// Purpose: SPI master and I2C 10-bit slave receive / master Start logic
// Assumes: ref_clk is the port oscillator; pins are open drain except SPI
// Notes:   Received bytes queue in an 8-word FIFO whose head is the buffer
`timescale 1ns/1ps

module ssip_port (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire ssip_pkg::ssip_cfg_t   cfg,
	input  wire logic                  periodTimerTick,
	input  wire logic                  txWrite,
	input  wire logic [7:0]            txData,
	input  wire logic                  bufRead,
	output logic      [7:0]            transferBuffer,
	input  wire logic                  addrWrite,
	input  wire logic [7:0]            addrWData,
	output logic      [7:0]            addressOrBaudReload,
	input  wire logic                  ckpWrite,
	input  wire logic                  ckpWData,
	input  wire logic                  sseWrite,
	input  wire logic                  sseWData,
	input  wire logic                  irqClear,
	input  wire logic                  bclClear,
	input  wire logic                  wcolClear,
	output ssip_pkg::ssip_flags_t      flags,
	output logic                       spiBusy,
	output logic                       serialClockLine,
	output logic                       serialDataOut,
	output logic                       serialDataOutEn,
	input  wire logic                  serialDataIn,
	input  wire logic                  i2cClockIn,
	output logic                       i2cClockOut,
	output logic                       i2cClockOe,
	input  wire logic                  i2cDataIn,
	output logic                       i2cDataOut,
	output logic                       i2cDataOe
);
	import ssip_pkg::*;

	// Pin synchronisers: first stage feeds only the second
	logic [2:0] meta_q;          // First stage
	logic [2:0] sync_q;          // Second stage, safe to read
	logic [2:0] prev_q;          // One cycle older, for edges
	logic       sdiS;            // Synced SPI input
	logic       sclS;            // Synced I2C clock
	logic       sdaS;            // Synced I2C data
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;

	// Mode decode
	logic spiMode;
	logic slvMode;
	logic mstMode;

	// SPI engine
	logic       spiActive_q;     // Byte in flight
	logic [3:0] halfCnt_q;       // Half clock periods done
	logic       sckActive_q;     // Clock away from idle level
	logic [7:0] shift_q;         // Shift register
	logic       sdo_q;           // Output data bit
	logic       brgTick;
	logic       halfTick;
	logic       txAccept;
	logic       txCollide;
	logic       spiStart;
	logic       sampleEdge;
	logic       changeEdge;
	logic       spiDone;
	logic [7:0] spiByte;
	logic [8:0] spiHalf;
	logic [8:0] brgReload;
	logic       brgRun;
	logic       brgLoad;
	logic [1:0] sampDly_q;       // Sample strobes waiting out the synchroniser
	logic [2:0] rxCnt_q;         // Bits taken into the receive byte
	logic [7:0] spiRx_q;         // Receive shift register
	logic       spiBusyW;        // Clocking or delayed samples still in flight
	logic       rxDone;          // Eighth delayed sample taken

	// FIFO hook-up
	logic       fifoInReady;
	logic       fifoOutValid;
	logic       fifoPush;
	logic [7:0] fifoInData;

	// I2C slave
	ssip_slv_t  slvState_q;
	ssip_slv_t  slvNext_q;       // State after the ack slot
	logic [3:0] bitCnt_q;
	logic [7:0] rxSh_q;
	logic       ackLow_q;        // Driving the ack bit
	logic       irqPend_q;       // Irq due at end of ack slot
	logic       uaHold_q;        // Clock held for address update
	logic       sclStretch_q;    // Clock line held low
	logic       byteEnd;
	logic       ackEnd;
	logic       highMatch;
	logic       lowMatch;
	logic       slvPush;
	logic       slvUa;
	logic       slvAck;
	logic       slvCkpClr;
	ssip_slv_t  slvAfter;

	// I2C master Start
	ssip_mst_t mstState_q;
	logic      sdaLow_q;         // Master holding data low
	logic      mstBegin;
	logic      mstCollide;
	logic      mstFormed;
	logic      mstDone;

	// Software visible bits
	logic [7:0] addr_q;
	logic       ckp_q;
	logic       sse_q;
	logic       irq_q;
	logic       ua_q;
	logic       startSeen_q;
	logic       bcl_q;
	logic       write_collision_flag_q;

	// Synchroniser chain
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			meta_q <= 3'h7;
			sync_q <= 3'h7;
			prev_q <= 3'h7;
		end
		else
		begin
			meta_q <= {serialDataIn, i2cClockIn, i2cDataIn};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign sdiS      = sync_q[2];
	assign sclS      = sync_q[1];
	assign sdaS      = sync_q[0];
	assign sclRise   = sclS & !prev_q[1];
	assign sclFall   = !sclS & prev_q[1];
	assign startCond = sclS & prev_q[1] & !sdaS & prev_q[0];
	assign stopCond  = sclS & prev_q[1] & sdaS & !prev_q[0];

	assign spiMode = cfg.mode == SSIP_SPI_MASTER;
	assign slvMode = cfg.mode == SSIP_I2C_SLAVE10;
	assign mstMode = cfg.mode == SSIP_I2C_MASTER;

	// Half period selection; timer/2 toggles the clock on each timer tick
	assign spiHalf = (cfg.rate == SSIP_RATE_DIV4)  ? HALF_DIV4 :
	                 (cfg.rate == SSIP_RATE_DIV16) ? HALF_DIV16 :
	                 (cfg.rate == SSIP_RATE_DIV64) ? HALF_DIV64 :
	                 {addr_q, 1'b1};
	assign halfTick = (cfg.rate == SSIP_RATE_TIMER) ? periodTimerTick : brgTick;

	// Writes are refused while busy, while collision is pending or FIFO full
	assign spiBusyW  = spiActive_q | (sampDly_q != 2'h0);
	assign txAccept  = txWrite & spiMode & !spiBusyW & !write_collision_flag_q & fifoInReady;
	assign txCollide = txWrite & spiMode & !txAccept;
	// Receive-only mode re-arms itself whenever there is room to land a byte
	assign spiStart  = txAccept |
	                   (spiMode & cfg.rxOnly & !spiBusyW & fifoInReady & !txWrite);
	// Edge bit set samples on the leading edge, else on the trailing one
	assign sampleEdge = halfTick & spiActive_q & (!halfCnt_q[0] == cfg.clockEdgeSel);
	assign changeEdge = halfTick & spiActive_q & (!halfCnt_q[0] != cfg.clockEdgeSel);
	assign spiDone    = halfTick & spiActive_q & (halfCnt_q == SPI_LAST_HALF);
	assign spiByte    = {spiRx_q[6:0], sdiS};
	assign rxDone     = sampDly_q[1] & (rxCnt_q == 3'h7);

	// Shared baud generator: SPI half periods or the I2C Start timing
	assign brgRun    = spiActive_q | (mstState_q == MS_SETUP) | (mstState_q == MS_HOLD);
	assign brgLoad   = spiStart | mstBegin;
	assign brgReload = spiMode ? spiHalf : {1'b0, addr_q};

	ssip_brg u_brg (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.run     (brgRun),
		.load    (brgLoad),
		.reload  (brgReload),
		.tick    (brgTick)
	);

	// SPI shifter: MSB out first, input enters at bit 0
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			spiActive_q <= 1'b0;
			halfCnt_q   <= '0;
			sckActive_q <= 1'b0;
			shift_q     <= '0;
			sdo_q       <= 1'b0;
		end
		else if (spiStart)
		begin
			spiActive_q <= 1'b1;
			halfCnt_q   <= '0;
			shift_q     <= txData;
			sdo_q       <= cfg.clockEdgeSel ? txData[7] : sdo_q;
		end
		else if (halfTick && spiActive_q)
		begin
			spiActive_q <= !spiDone;
			halfCnt_q   <= halfCnt_q + 1'b1;
			sckActive_q <= !sckActive_q;
			shift_q     <= sampleEdge ? {shift_q[6:0], sdiS} : shift_q;
			sdo_q       <= (changeEdge && !spiDone) ? shift_q[7] : sdo_q;
		end
	end

	// The input pin passes two flops, so each sample is taken two clocks after
	// its clock edge; the far side holds the bit until the opposite edge, which
	// is at least two clocks later even at the fastest rate
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			sampDly_q <= 2'h0;
			rxCnt_q   <= 3'h0;
			spiRx_q   <= 8'h00;
		end
		else
		begin
			sampDly_q <= {sampDly_q[0], sampleEdge};
			rxCnt_q   <= spiStart ? 3'h0 : rxCnt_q + {2'h0, sampDly_q[1]};
			spiRx_q   <= sampDly_q[1] ? {spiRx_q[6:0], sdiS} : spiRx_q;
		end
	end

	// Byte source for the FIFO; SPI and slave never run together
	assign fifoPush   = rxDone | slvPush;
	assign fifoInData = spiMode ? spiByte : rxSh_q;

	// Head of the FIFO is the transfer buffer; a read pops it
	ssip_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.inData   (fifoInData),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.outData  (transferBuffer),
		.outValid (fifoOutValid),
		.outReady (bufRead)
	);

	// Slave byte evaluation on the falling edge after the eighth bit
	assign byteEnd   = slvMode & sclFall & (bitCnt_q == I2C_BYTE_BITS) &
	                   (slvState_q inside {SL_HIGH, SL_LOW, SL_DATA});
	assign ackEnd    = slvMode & sclFall & (slvState_q == SL_ACK);
	assign highMatch = (rxSh_q[7:1] == addr_q[7:1]) & !rxSh_q[0];
	assign lowMatch  = rxSh_q == addr_q;
	assign slvUa     = byteEnd & (slvState_q != SL_DATA) &
	                   (highMatch | (slvState_q == SL_LOW));
	assign slvPush   = byteEnd & fifoInReady &
	                   (((slvState_q == SL_HIGH) & highMatch) |
	                    ((slvState_q == SL_LOW) & lowMatch) | (slvState_q == SL_DATA));
	assign slvAck    = slvPush;
	// Address hold acts on matched address bytes, stretch or data hold on data
	assign slvCkpClr = byteEnd &
	                   (((slvState_q == SL_DATA) & (sse_q | cfg.dataHoldEnable)) |
	                    (slvPush & (slvState_q != SL_DATA) & cfg.addressHoldEnable));
	assign slvAfter  = !slvPush ? SL_SKIP :
	                   (slvState_q == SL_HIGH) ? SL_LOW : SL_DATA;

	// Slave receive sequence
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || !slvMode || stopCond)
		begin
			slvState_q <= SL_IDLE;
			slvNext_q  <= SL_IDLE;
			bitCnt_q   <= '0;
			ackLow_q   <= 1'b0;
			irqPend_q  <= 1'b0;
		end
		else if (startCond)
		begin
			slvState_q <= SL_HIGH;
			bitCnt_q   <= '0;
			ackLow_q   <= 1'b0;
		end
		else if (byteEnd)
		begin
			slvState_q <= SL_ACK;
			slvNext_q  <= slvAfter;
			ackLow_q   <= slvAck;
			irqPend_q  <= slvPush | slvUa;
		end
		else if (ackEnd)
		begin
			slvState_q <= slvNext_q;
			bitCnt_q   <= '0;
			ackLow_q   <= 1'b0;
			irqPend_q  <= 1'b0;
		end
		else if (sclRise && slvState_q != SL_IDLE && slvState_q != SL_ACK)
		begin
			rxSh_q   <= {rxSh_q[6:0], sdaS};
			bitCnt_q <= bitCnt_q + 1'b1;
		end
	end

	// Clock stretching: held after the ack slot until software releases it
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || !slvMode)
		begin
			uaHold_q     <= 1'b0;
			sclStretch_q <= 1'b0;
		end
		else
		begin
			uaHold_q     <= slvUa | (uaHold_q & !addrWrite);
			sclStretch_q <= (ackEnd & (uaHold_q | !ckp_q)) |
			                (sclStretch_q & (uaHold_q | !ckp_q));
		end
	end

	// Master Start sequence
	assign mstBegin   = mstMode & sse_q & (mstState_q == MS_IDLE) & sclS & sdaS;
	assign mstCollide = mstMode & sse_q &
	                    (((mstState_q == MS_IDLE) & !(sclS & sdaS)) |
	                     ((mstState_q == MS_SETUP) & (!sclS | (brgTick & !sdaS))));
	assign mstFormed  = (mstState_q == MS_SETUP) & brgTick & sclS & sdaS;
	assign mstDone    = (mstState_q == MS_HOLD) & brgTick;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn || !mstMode || mstCollide)
		begin
			mstState_q <= MS_IDLE;
			sdaLow_q   <= 1'b0;
		end
		else
		begin
			unique case (mstState_q)
				MS_IDLE:  mstState_q <= mstBegin ? MS_SETUP : MS_IDLE;
				MS_SETUP: mstState_q <= mstFormed ? MS_HOLD : MS_SETUP;
				MS_HOLD:  mstState_q <= mstDone ? MS_DONE : MS_HOLD;
				MS_DONE:  mstState_q <= MS_DONE;
			endcase
			sdaLow_q <= sdaLow_q | mstFormed;
		end
	end

	// Software bits; hardware events win over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			addr_q      <= ADDR_RESET;
			ckp_q       <= CKP_RESET;
			sse_q       <= 1'b0;
			irq_q       <= 1'b0;
			ua_q        <= 1'b0;
			startSeen_q <= 1'b0;
			bcl_q       <= 1'b0;
			write_collision_flag_q      <= 1'b0;
		end
		else
		begin
			addr_q      <= addrWrite ? addrWData : addr_q;
			// Hardware clear wins here so a held byte is never released early
			ckp_q       <= slvCkpClr ? 1'b0 : (ckpWrite ? ckpWData : ckp_q);
			sse_q       <= sseWrite ? sseWData : (sse_q & !mstDone & !mstCollide);
			irq_q       <= rxDone | (ackEnd & irqPend_q) | mstDone |
			               (startCond & slvMode & cfg.startIrqEn) |
			               (irq_q & !irqClear);
			ua_q        <= slvUa | (ua_q & !addrWrite);
			startSeen_q <= (startCond & slvMode) | mstFormed |
			               (startSeen_q & !stopCond);
			bcl_q       <= mstCollide | (bcl_q & !bclClear);
			write_collision_flag_q      <= txCollide | (write_collision_flag_q & !wcolClear);
		end
	end

	// Outputs
	assign addressOrBaudReload        = addr_q;
	assign flags.bufferFullFlag       = fifoOutValid;
	assign flags.portInterruptFlag    = irq_q;
	assign flags.updateAddressFlag    = ua_q;
	assign flags.startSeen            = startSeen_q;
	assign flags.busCollisionFlag     = bcl_q;
	assign flags.writeCollisionFlag   = write_collision_flag_q;
	assign flags.clockPolarityHold    = ckp_q;
	assign flags.startOrStretchEnable = sse_q;
	assign spiBusy                    = spiBusyW;
	assign serialClockLine            = ckp_q ^ sckActive_q;
	assign serialDataOut              = sdo_q;
	assign serialDataOutEn            = spiMode & !cfg.rxOnly;
	assign i2cClockOut                = 1'b0;
	assign i2cClockOe                 = sclStretch_q;
	assign i2cDataOut                 = 1'b0;
	assign i2cDataOe                  = sdaLow_q | ackLow_q;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_setupTimeout;
		(mstState_q == MS_SETUP) && brgTick && sclS && sdaS;
	endsequence

	sequence s_holdTimeout;
		(mstState_q == MS_HOLD) && brgTick;
	endsequence

	a_tx_start_now: assert property (txAccept |=> spiActive_q && halfCnt_q == 4'h0)
		else $error("accepted write did not start a byte");
	a_rx_only_run: assert property (spiStart && !txAccept |=> spiActive_q)
		else $error("receive-only byte did not start");
	a_rate_div4: assert property (spiActive_q && cfg.rate == SSIP_RATE_DIV4 && halfTick
		&& halfCnt_q != SPI_LAST_HALF |=> !halfTick ##1 halfTick)
		else $error("divide by four half period wrong");
	a_msb_first: assert property (txAccept && cfg.clockEdgeSel
		|=> serialDataOut == $past(txData[7]))
		else $error("first output bit is not the top bit");
	a_idle_polarity: assert property (!spiActive_q |-> serialClockLine == ckp_q)
		else $error("idle clock level differs from polarity");
	a_write_collision_flag_set: assert property (txCollide |=> write_collision_flag_q && !spiStart)
		else $error("refused write did not flag collision");
	a_done_flags: assert property (rxDone |=> fifoOutValid && irq_q)
		else $error("finished byte did not raise full and irq");
	a_start_formed: assert property (s_setupTimeout |=> sdaLow_q && startSeen_q)
		else $error("start not formed after timeout");
	a_start_done: assert property (s_holdTimeout |=> !sse_q && sdaLow_q
		&& mstState_q == MS_DONE)
		else $error("start request not cleared after hold period");
	a_collide_idle: assert property (mstCollide |=> bcl_q && mstState_q == MS_IDLE
		&& !sdaLow_q)
		else $error("collision did not abort start");
	a_addr_release: assert property (uaHold_q && addrWrite && !slvUa |=> !uaHold_q)
		else $error("address write did not release clock hold");
endmodule

// file: rtl/ssip_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port
// Assumes: One 40 MHz clock (25 ns period) that is also the port oscillator
// Notes:   Sizes, baud reloads, sequence counts and the address and polarity reset values live here
package ssip_pkg;

	// Data and structure sizes
	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int BRG_W      = 9;

	// Baud generator reloads for half an SPI clock period (count is reload + 1)
	localparam logic [8:0] HALF_DIV4  = 9'h001;
	localparam logic [8:0] HALF_DIV16 = 9'h007;
	localparam logic [8:0] HALF_DIV64 = 9'h01f;

	// Sequence counts
	localparam logic [3:0] SPI_LAST_HALF = 4'hf;
	localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

	// Reset values
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic       CKP_RESET  = 1'b0;

	// Operating modes; code 2'b11 is illegal
	typedef enum logic [1:0] {
		SSIP_SPI_MASTER  = 2'b00,
		SSIP_I2C_SLAVE10 = 2'b01,
		SSIP_I2C_MASTER  = 2'b10
	} ssip_mode_t;

	// SPI bit rate choices
	typedef enum logic [2:0] {
		SSIP_RATE_DIV4  = 3'b000,
		SSIP_RATE_DIV16 = 3'b001,
		SSIP_RATE_DIV64 = 3'b010,
		SSIP_RATE_TIMER = 3'b011,
		SSIP_RATE_BAUD  = 3'b100
	} ssip_rate_t;

	// I2C slave receive states
	typedef enum logic [2:0] {
		SL_IDLE = 3'b000,
		SL_HIGH = 3'b001,
		SL_LOW  = 3'b010,
		SL_DATA = 3'b011,
		SL_ACK  = 3'b100,
		SL_SKIP = 3'b101
	} ssip_slv_t;

	// I2C master Start states
	typedef enum logic [1:0] {
		MS_IDLE  = 2'b00,
		MS_SETUP = 2'b01,
		MS_HOLD  = 2'b10,
		MS_DONE  = 2'b11
	} ssip_mst_t;

	// Static configuration written by software
	typedef struct packed {
		ssip_mode_t mode;
		ssip_rate_t rate;
		logic       clockEdgeSel;
		logic       rxOnly;
		logic       startIrqEn;
		logic       addressHoldEnable;
		logic       dataHoldEnable;
	} ssip_cfg_t;

	// Status seen by software
	typedef struct packed {
		logic bufferFullFlag;
		logic portInterruptFlag;
		logic updateAddressFlag;
		logic startSeen;
		logic busCollisionFlag;
		logic writeCollisionFlag;
		logic clockPolarityHold;
		logic startOrStretchEnable;
	} ssip_flags_t;

endpackage

// file: rtl/ssip_fifo.sv
// Purpose: Receive byte FIFO between the shifter and the transfer buffer
// Assumes: DEPTH is a power of two
// Notes:   Head word comes straight from the storage flops
`timescale 1ns/1ps
module ssip_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage words
	logic [AW-1:0]    wrPtr_q;       // Next slot to fill
	logic [AW-1:0]    rdPtr_q;       // Head slot
	logic [AW:0]      count_q;       // Words held
	logic             push;
	logic             pop;

	// Honest full and empty from the word count
	assign inReady  = count_q != (AW + 1)'(DEPTH);
	assign outValid = count_q != '0;
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Storage needs no reset; only the pointers and the word count carry state
	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wrPtr_q] <= inData;
		end
	end

	// Pointer and count update
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_q + AW'(push);
			rdPtr_q <= rdPtr_q + AW'(pop);
			count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// file: rtl/ssip_brg.sv
// Purpose: Reloadable baud rate down counter
// Assumes: reload is stable while run is high
// Notes:   tick pulses once every reload + 1 clocks while running
`timescale 1ns/1ps
module ssip_brg (
	input  wire logic                      ref_clk,
	input  wire logic                      resetn,
	input  wire logic                      run,
	input  wire logic                      load,
	input  wire logic [ssip_pkg::BRG_W-1:0] reload,
	output logic                           tick
);
	import ssip_pkg::*;

	logic [BRG_W-1:0] count_q;   // Remaining clocks in this period

	// A load restarts the period, so no stale tick leaks out
	assign tick = run & !load & (count_q == '0);

	// Count down, reloading itself on every timeout
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			count_q <= '0;
		end
		else if (load || tick)
		begin
			count_q <= reload;
		end
		else if (run)
		begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule

// file: tb/ssip_spi_slave.sv
// Purpose: Small SPI slave that answers the port's master
// Assumes: Polarity bit clear, so the leading clock edge rises
// Notes:   Spent bits come back inverted so no stale level lingers
`timescale 1ns/1ps
module ssip_spi_slave (
	input  wire logic       sck,
	input  wire logic       sdo,
	input  wire logic       load,
	input  wire logic [7:0] resp,
	output logic            sdi,
	output logic      [7:0] got
);
	logic [7:0] txQ; // Bits still to send
	assign sdi = txQ[7];
	// Take the master's bit on the leading edge
	always @(posedge sck)
		got <= {got[6:0], sdo};
	// Next bit on the trailing edge, so it is settled before sampling
	always @(negedge sck or posedge load)
		if (load)
			txQ <= resp;
		else
			txQ <= {txQ[6:0], ~txQ[7]};
endmodule

// file: tb/ssip_port_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Pull-ups on both I2C wires
// Notes:   Rates judged by differences, so fixed overhead cancels
`timescale 1ns/1ps
module ssip_port_tb;
	import ssip_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	ssip_cfg_t   cfg = '0;
	logic        txWrite = 1'b0, bufRead = 1'b0, addrWrite = 1'b0, sseWrite = 1'b0;
	logic        irqClear = 1'b0, wcolClear = 1'b0, bclClear = 1'b0, load = 1'b0;
	logic        sclLow = 1'b0; // Another party pulls the I2C clock low
	logic        sdaLow = 1'b0, ckpWrite = 1'b0; // Bus master data pull, hold-bit write
	logic [7:0]  txData = 8'h00, addrWData = 8'h00, resp = 8'h00, buffer, got;
	ssip_flags_t flags;
	logic        spiBusy, sck, sdo, sdoEn, sdi, sclOe, sdaOe;
	int          error_cnt = 0, n_compared = 0;
	int          n[4];

	ssip_port i_ssip_port (.ref_clk(ref_clk), .resetn(resetn), .cfg(cfg),
		.periodTimerTick(1'b0), .txWrite(txWrite), .txData(txData), .bufRead(bufRead),
		.transferBuffer(buffer), .addrWrite(addrWrite), .addrWData(addrWData),
		.addressOrBaudReload(), .ckpWrite(ckpWrite), .ckpWData(1'b1), .sseWrite(sseWrite),
		.sseWData(1'b1), .irqClear(irqClear), .bclClear(bclClear), .wcolClear(wcolClear),
		.flags(flags), .spiBusy(spiBusy), .serialClockLine(sck), .serialDataOut(sdo),
		.serialDataOutEn(sdoEn), .serialDataIn(sdi), .i2cClockIn(~sclOe & ~sclLow),
		.i2cClockOut(), .i2cClockOe(sclOe), .i2cDataIn(~sdaOe & ~sdaLow), .i2cDataOut(),
		.i2cDataOe(sdaOe));
	ssip_spi_slave i_ssip_spi_slave (.sck(sck), .sdo(sdo), .load(load), .resp(resp),
		.sdi(sdi), .got(got));

	// Free-running 40 MHz clock
	initial forever #12.5 ref_clk = ~ref_clk;

	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Drives change just after the edge
	task automatic step(int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// One byte out; k counts busy cycles, bounded
	task automatic xfer(logic [7:0] d, output int k);
		resp = ~d; load = 1'b1; txData = d; txWrite = 1'b1;
		step(1);
		load = 1'b0; txWrite = 1'b0; k = 0;
		while (spiBusy !== 1'b0 && k < 2000)
		begin
			step(1);
			k++;
		end
		step(1); // Flags land no later than the cycle that busy drops
	endtask
	task automatic pop(logic [7:0] exp);
		chk("buffer", buffer, exp);
		bufRead = 1'b1; step(1); bufRead = 1'b0; step(1);
	endtask

	// Basic byte plus a write while busy
	task automatic t_spi();
		cfg.clockEdgeSel = 1'b1;
		xfer(8'ha5, n[0]);
		chk("slave got", got, 8'ha5);
		chk("full irq", {flags.bufferFullFlag, flags.portInterruptFlag}, 2'b11);
		pop(8'h5a);
		chk("full", flags.bufferFullFlag, 1'b0);
		txWrite = 1'b1; step(2); txWrite = 1'b0; step(40);
		chk("write_collision_flag", flags.writeCollisionFlag, 1'b1);
		pop(8'ha5);
		irqClear = 1'b1; wcolClear = 1'b1; step(1); irqClear = 1'b0; wcolClear = 1'b0;
		$display("test spi done");
	endtask
	// Rates: half periods 2, 8, 32 and 2*(5+1) clocks
	task automatic t_rate();
		ssip_rate_t r[4] = '{SSIP_RATE_DIV4, SSIP_RATE_DIV16, SSIP_RATE_DIV64, SSIP_RATE_BAUD};
		int h[4] = '{2, 8, 32, 12};
		addrWData = 8'h05; addrWrite = 1'b1; step(1); addrWrite = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			cfg.rate = r[i];
			xfer(8'h3c, n[i]);
			pop(8'hc3);
			chk("rate span", 16'(n[i] - n[0]), 16'(16 * (h[i] - 2)));
		end
		cfg.rate = SSIP_RATE_DIV4;
		$display("test rate done");
	endtask
	// Fill the queue until refused, then drain in order
	task automatic t_fifo();
		for (int i = 0; i < 8; i++)
			xfer(8'(i), n[0]);
		txWrite = 1'b1; step(1); txWrite = 1'b0; step(1);
		chk("write_collision_flag full", flags.writeCollisionFlag, 1'b1);
		for (int i = 0; i < 8; i++)
			pop(~8'(i));
		chk("empty", flags.bufferFullFlag, 1'b0);
		wcolClear = 1'b1; step(1); wcolClear = 1'b0;
		$display("test fifo done");
	endtask
	// Receive-only keeps clocking bytes in by itself
	task automatic t_rx();
		cfg.rxOnly = 1'b1;
		txWrite = 1'b1; step(1); txWrite = 1'b0; step(100);
		chk("sdo off", sdoEn, 1'b0);
		cfg.rxOnly = 1'b0; step(40);
		bufRead = 1'b1; step(1); bufRead = 1'b0; step(1);
		chk("second byte", flags.bufferFullFlag, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			bufRead = flags.bufferFullFlag; step(1); bufRead = 1'b0; step(1);
		end
		$display("test rx done");
	endtask
	// Start on a free bus, then on a bus held low
	task automatic t_start();
		cfg.mode = SSIP_I2C_MASTER;
		addrWData = 8'h03; addrWrite = 1'b1; sseWrite = 1'b1; step(1);
		addrWrite = 1'b0; sseWrite = 1'b0; step(30);
		chk("start", {flags.startSeen, sdaOe, flags.startOrStretchEnable}, 3'b110);
		chk("no bcl", flags.busCollisionFlag, 1'b0);
		cfg.mode = SSIP_SPI_MASTER; sclLow = 1'b1; step(5);
		cfg.mode = SSIP_I2C_MASTER; sseWrite = 1'b1; step(1); sseWrite = 1'b0; step(15);
		chk("bcl", {flags.busCollisionFlag, flags.startOrStretchEnable}, 2'b10);
		bclClear = 1'b1; step(1); bclClear = 1'b0;
		$display("test start done");
	endtask

	// Eight data bits, then the ninth pulse left high for the ack check
	task automatic i2c_byte(logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			sdaLow = ~b[i]; step(4); sclLow = 1'b0; step(6); sclLow = 1'b1; step(4);
		end
		sdaLow = 1'b0; step(4); sclLow = 1'b0; step(6);
	endtask
	// 10-bit slave: stop, start, both address bytes, one stretched data byte
	task automatic t_slave();
		cfg.mode = SSIP_I2C_SLAVE10; sdaLow = 1'b1; irqClear = 1'b1; ckpWrite = 1'b1;
		sseWrite = 1'b1; addrWData = 8'hf2; addrWrite = 1'b1; step(1);
		irqClear = 1'b0; ckpWrite = 1'b0; sseWrite = 1'b0; addrWrite = 1'b0; step(5);
		sclLow = 1'b0; step(5); sdaLow = 1'b0; step(5);
		chk("stop", flags.startSeen, 1'b0);
		sdaLow = 1'b1; step(5);
		chk("start", {flags.startSeen, flags.portInterruptFlag}, 2'b10);
		sclLow = 1'b1; step(4);
		i2c_byte(8'hf2);
		chk("ack high", sdaOe, 1'b1);
		sclLow = 1'b1; step(6);
		chk("high", {flags.portInterruptFlag, flags.updateAddressFlag, sclOe}, 3'b111);
		irqClear = 1'b1; step(1); irqClear = 1'b0;
		pop(8'hf2);
		addrWData = 8'h5c; addrWrite = 1'b1; step(1); addrWrite = 1'b0; step(2);
		chk("released", sclOe, 1'b0);
		i2c_byte(8'h5c);
		chk("ack low", sdaOe, 1'b1);
		sclLow = 1'b1; step(6);
		chk("low", {flags.portInterruptFlag, flags.updateAddressFlag,
			flags.bufferFullFlag}, 3'b111);
		irqClear = 1'b1; step(1); irqClear = 1'b0;
		pop(8'h5c);
		addrWData = 8'hf2; addrWrite = 1'b1; step(1); addrWrite = 1'b0; step(2);
		i2c_byte(8'h3a);
		chk("ack data", sdaOe, 1'b1);
		sclLow = 1'b1; step(6);
		chk("stretch", {flags.portInterruptFlag, flags.clockPolarityHold, sclOe}, 3'b101);
		pop(8'h3a);
		ckpWrite = 1'b1; step(1); ckpWrite = 1'b0; step(3);
		chk("clock free", sclOe, 1'b0);
		$display("test slave done");
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog, far beyond the few thousand cycles the tests need
	initial
	begin
		step(20000);
		error_cnt++;
		close_out();
	end
	initial
	begin
		step(8);
		resetn = 1'b1;
		t_spi();
		t_rate();
		t_fifo();
		t_rx();
		t_start();
		t_slave();
		close_out();
	end
endmodule
